// >>> common/upac_pkg.sv
// constants, field layout and carrier types for the cell-bus configuration bank
package upac_pkg;
	// register indices; byte address on the bus is four times the index
	localparam logic [7:0] IDX_USER_BYTE = 8'h12;
	localparam logic [7:0] IDX_BUS_MODE = 8'h13;
	localparam logic [7:0] IDX_LINK_ADDR_BASE = 8'h40;
	localparam logic [7:0] IDX_GROUP_ADDR_BASE = 8'h48;
	localparam logic [7:0] IDX_LINK_ENABLE = 8'h50;
	localparam logic [7:0] IDX_GROUP_ENABLE = 8'h51;
	localparam int NUM_LINK_ADDR_REGS = 8;
	localparam int NUM_GROUP_ADDR_REGS = 4;
	localparam int NUM_LINKS = 16;
	localparam int NUM_GROUPS = 8;

	// storage masks: bits outside a mask are not kept and read as zero
	localparam logic [15:0] MASK_USER_BYTE = 16'h0fff;
	localparam logic [15:0] MASK_ADDR_PAIR = 16'h1f1f;
	localparam logic [15:0] MASK_LINK_ENABLE = 16'hffff;
	localparam logic [15:0] MASK_GROUP_ENABLE = 16'h0fff;
	localparam logic [15:0] MASK_BUS_MODE = 16'h0001;

	// reset values
	localparam logic [15:0] RST_USER_BYTE = 16'h0000;
	localparam logic [15:0] RST_ADDR_PAIR = 16'h0000;
	localparam logic [15:0] RST_LINK_ENABLE = 16'h0000;
	localparam logic [15:0] RST_GROUP_ENABLE = 16'h0000;
	localparam logic [15:0] RST_BUS_MODE = 16'h0000;

	// field positions
	localparam int UDB_LSB = 0;
	localparam int UDB_MSB = 7;
	localparam int PAR_EVEN_BIT = 8;
	localparam int PAR_TRISTATE_BIT = 9;
	localparam int MODE_8BIT_BIT = 0;
	localparam int ADDR_LO_LSB = 0;
	localparam int ADDR_HI_LSB = 8;
	localparam int ADDR_W = 5;

	// cell layout on a 16-bit bus: word 2 carries the fifth and sixth header bytes
	localparam logic [4:0] CELL_UDF_WORD = 5'h02;

	// one word offered to the output cell bus
	typedef struct packed {
		logic [15:0] data;
		logic [4:0] idx;
	} upac_cell_word_s;

	// one word driven out on the output cell bus
	typedef struct packed {
		logic [15:0] data;
		logic parity;
		logic parity_oe;
		logic valid;
	} upac_out_word_s;
endpackage

// >>> core/upac_top.sv
// cell-bus configuration bank with apb slave, output byte/parity path and address match
//
// Contract
// R01 - user byte replaces sixth header byte; the code inserts it in 16-bit mode only
// R02 - parity even when select set, else odd
// R03 - parity tristate bit releases parity pin
// R04 - unused register bits always read zero; user byte bits 11:10 and group enable bits 11:8 read back as written
// R05 - eight link address pairs, N and N+8
// R06 - four group address pairs, N and N+4
// R07 - link enable bit N activates link address
// R08 - group enable bits 7:0 activate group addresses
// R09 - software writes zeros to reserved bits
// R10 - mode bit selects eight or sixteen bit
// R11 - answer only enabled link or group addresses
module upac_top (
	input wire logic i_clk_sys, // 20 MHz system clock
	input wire logic i_srst, // synchronous reset, active high
	input wire logic [11:0] i_paddr, // apb byte address
	input wire logic i_psel, // apb select
	input wire logic i_penable, // apb access phase
	input wire logic i_pwrite, // apb direction, high for write
	input wire logic [31:0] i_pwdata, // apb write data
	input wire logic [3:0] i_pstrb, // apb byte strobes
	output logic [31:0] o_prdata, // apb read data, registered
	output logic o_pready, // apb ready
	output logic o_pslverr, // apb error, registered
	input wire upac_pkg::upac_cell_word_s i_cell_word, // word from the cell core
	input wire logic i_cell_valid, // word valid strobe
	output upac_pkg::upac_out_word_s o_cell_out, // word on the output bus, registered
	output logic o_bus_8bit, // output bus width, high for 8-bit
	input wire logic [4:0] i_in_phy_addr, // polled or selected input address
	input wire logic i_in_addr_valid, // address valid strobe
	output logic o_in_addr_hit, // address belongs to an enabled port, registered
	output logic o_in_hit_group, // hit came from a group, registered
	output logic [3:0] o_in_hit_index // link or group number of the hit, registered
);
	// register storage
	logic [15:0] user_byte;
	logic [15:0] next_user_byte;
	logic [15:0] bus_mode;
	logic [15:0] next_bus_mode;
	logic [15:0] link_enable;
	logic [15:0] next_link_enable;
	logic [15:0] group_enable;
	logic [15:0] next_group_enable;
	logic [15:0] link_addr [0:upac_pkg::NUM_LINK_ADDR_REGS-1];
	logic [15:0] next_link_addr [0:upac_pkg::NUM_LINK_ADDR_REGS-1];
	logic [15:0] group_addr [0:upac_pkg::NUM_GROUP_ADDR_REGS-1];
	logic [15:0] next_group_addr [0:upac_pkg::NUM_GROUP_ADDR_REGS-1];

	// bus slave state
	logic [31:0] prdata;
	logic [31:0] next_prdata;
	logic pslverr;
	logic next_pslverr;
	logic [7:0] reg_idx;
	logic idx_ok;
	logic [15:0] rd_word;
	logic setup_phase;
	logic wr_take;
	logic [15:0] wr_word;

	// output path state
	upac_pkg::upac_out_word_s cell_out;
	upac_pkg::upac_out_word_s next_cell_out;

	// address match state
	logic hit;
	logic next_hit;
	logic hit_group;
	logic next_hit_group;
	logic [3:0] hit_index;
	logic [3:0] next_hit_index;
	logic [upac_pkg::NUM_LINKS-1:0] link_match;
	logic [upac_pkg::NUM_GROUPS-1:0] group_match;

	// decode: index is byte address over four, low two bits must be clear
	assign reg_idx = i_paddr[9:2];
	assign setup_phase = i_psel && !i_penable;
	// zero-wait slave: read data is latched in setup, so access always completes at once
	assign o_pready = 1'b1;
	assign wr_take = i_psel && i_penable && i_pwrite && !pslverr;
	// write data merged by the two low byte strobes; upper lanes hold nothing
	assign wr_word = {i_pstrb[1] ? i_pwdata[15:8] : rd_word[15:8],
		i_pstrb[0] ? i_pwdata[7:0] : rd_word[7:0]};

	// read mux; masks zero bits outside each mask, user byte bits 11:10 and group enable bits 11:8 read as stored
	always_comb
	begin
		rd_word = 16'h0000;
		idx_ok = (i_paddr[1:0] == 2'b00) && (i_paddr[11:10] == 2'b00);
		if (reg_idx == upac_pkg::IDX_USER_BYTE)
			rd_word = user_byte & upac_pkg::MASK_USER_BYTE; // R04
		else if (reg_idx == upac_pkg::IDX_BUS_MODE)
			rd_word = bus_mode & upac_pkg::MASK_BUS_MODE; // R04
		else if (reg_idx >= upac_pkg::IDX_LINK_ADDR_BASE && reg_idx < upac_pkg::IDX_GROUP_ADDR_BASE)
			rd_word = link_addr[reg_idx[2:0]] & upac_pkg::MASK_ADDR_PAIR; // R04
		else if (reg_idx >= upac_pkg::IDX_GROUP_ADDR_BASE &&
			reg_idx < upac_pkg::IDX_GROUP_ADDR_BASE + 8'h04)
			rd_word = group_addr[reg_idx[1:0]] & upac_pkg::MASK_ADDR_PAIR; // R04
		else if (reg_idx == upac_pkg::IDX_LINK_ENABLE)
			rd_word = link_enable & upac_pkg::MASK_LINK_ENABLE;
		else if (reg_idx == upac_pkg::IDX_GROUP_ENABLE)
			rd_word = group_enable & upac_pkg::MASK_GROUP_ENABLE; // R04
		else
			idx_ok = 1'b0;
	end

	// bus answer: captured in the setup cycle and held through the access cycle
	always_comb
	begin
		next_prdata = prdata;
		next_pslverr = pslverr;
		if (setup_phase)
		begin
			// a refused access answers zero data as well as the error flag
			next_prdata = idx_ok ? {16'h0000, rd_word} : 32'h00000000; // R04
			next_pslverr = !idx_ok;
		end
		// the access cycle keeps what setup latched; the master samples it at ready
		if (!i_psel)
		begin
			next_prdata = 32'h00000000;
			next_pslverr = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// answer flops drive the bus straight, so read data never glitches
	assign o_prdata = prdata;
	assign o_pslverr = pslverr;

	// register writes; reserved bits are stored as written, software keeps them zero
	always_comb
	begin
		next_user_byte = user_byte;
		next_bus_mode = bus_mode;
		next_link_enable = link_enable;
		next_group_enable = group_enable;
		for (int i = 0; i < upac_pkg::NUM_LINK_ADDR_REGS; i++)
			next_link_addr[i] = link_addr[i];
		for (int i = 0; i < upac_pkg::NUM_GROUP_ADDR_REGS; i++)
			next_group_addr[i] = group_addr[i];
		if (wr_take)
		begin
			if (reg_idx == upac_pkg::IDX_USER_BYTE)
				next_user_byte = wr_word & upac_pkg::MASK_USER_BYTE; // R09
			else if (reg_idx == upac_pkg::IDX_BUS_MODE)
				next_bus_mode = wr_word & upac_pkg::MASK_BUS_MODE; // R10
			else if (reg_idx >= upac_pkg::IDX_LINK_ADDR_BASE &&
				reg_idx < upac_pkg::IDX_GROUP_ADDR_BASE)
				next_link_addr[reg_idx[2:0]] = wr_word & upac_pkg::MASK_ADDR_PAIR; // R05
			else if (reg_idx >= upac_pkg::IDX_GROUP_ADDR_BASE &&
				reg_idx < upac_pkg::IDX_GROUP_ADDR_BASE + 8'h04)
				next_group_addr[reg_idx[1:0]] = wr_word & upac_pkg::MASK_ADDR_PAIR; // R06
			else if (reg_idx == upac_pkg::IDX_LINK_ENABLE)
				next_link_enable = wr_word & upac_pkg::MASK_LINK_ENABLE; // R07
			else if (reg_idx == upac_pkg::IDX_GROUP_ENABLE)
				next_group_enable = wr_word & upac_pkg::MASK_GROUP_ENABLE; // R09
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			user_byte <= upac_pkg::RST_USER_BYTE;
			bus_mode <= upac_pkg::RST_BUS_MODE;
			link_enable <= upac_pkg::RST_LINK_ENABLE;
			group_enable <= upac_pkg::RST_GROUP_ENABLE;
			for (int i = 0; i < upac_pkg::NUM_LINK_ADDR_REGS; i++)
				link_addr[i] <= upac_pkg::RST_ADDR_PAIR;
			for (int i = 0; i < upac_pkg::NUM_GROUP_ADDR_REGS; i++)
				group_addr[i] <= upac_pkg::RST_ADDR_PAIR;
		end
		else
		begin
			user_byte <= next_user_byte;
			bus_mode <= next_bus_mode;
			link_enable <= next_link_enable;
			group_enable <= next_group_enable;
			for (int i = 0; i < upac_pkg::NUM_LINK_ADDR_REGS; i++)
				link_addr[i] <= next_link_addr[i];
			for (int i = 0; i < upac_pkg::NUM_GROUP_ADDR_REGS; i++)
				group_addr[i] <= next_group_addr[i];
		end
	end

	// width flag for the far side, taken straight from the mode register
	assign o_bus_8bit = bus_mode[upac_pkg::MODE_8BIT_BIT]; // R10

	// output path: one cycle of latency, byte insertion then parity on the final word
	always_comb
	begin
		logic [15:0] word;
		word = i_cell_word.data;
		next_cell_out = cell_out;
		next_cell_out.valid = i_cell_valid;
		// insertion only in 16-bit mode; the 8-bit bus carries no sixth byte slot
		if (!bus_mode[upac_pkg::MODE_8BIT_BIT] && i_cell_word.idx == upac_pkg::CELL_UDF_WORD) // R10
			word[7:0] = user_byte[upac_pkg::UDB_MSB:upac_pkg::UDB_LSB]; // R01
		// in 8-bit mode only the low lane is live, so the high lane is forced quiet
		if (bus_mode[upac_pkg::MODE_8BIT_BIT])
			word[15:8] = 8'h00;
		if (i_cell_valid)
		begin
			next_cell_out.data = word;
			// even: parity makes the count of ones even; odd: the reverse
			next_cell_out.parity = user_byte[upac_pkg::PAR_EVEN_BIT] ? (^word) : ~(^word); // R02
		end
		next_cell_out.parity_oe = !user_byte[upac_pkg::PAR_TRISTATE_BIT]; // R03
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			cell_out.data <= 16'h0000;
			cell_out.parity <= 1'b0;
			cell_out.parity_oe <= 1'b0;
			cell_out.valid <= 1'b0;
		end
		else
			cell_out <= next_cell_out;
	end

	// parity release is left to the pad: only the enable leaves here
	assign o_cell_out = cell_out;

	// per-port comparators: link N from pair reg N mod 8, group N from pair reg N mod 4
	for (genvar k = 0; k < upac_pkg::NUM_LINKS; k++)
	begin : g_link
		localparam int LSB = (k < 8) ? upac_pkg::ADDR_LO_LSB : upac_pkg::ADDR_HI_LSB;
		assign link_match[k] = link_enable[k] &&
			(link_addr[k % 8][LSB +: upac_pkg::ADDR_W] == i_in_phy_addr); // R05 R07 R11
	end
	for (genvar g = 0; g < upac_pkg::NUM_GROUPS; g++)
	begin : g_group
		localparam int LSB = (g < 4) ? upac_pkg::ADDR_LO_LSB : upac_pkg::ADDR_HI_LSB;
		assign group_match[g] = group_enable[g] &&
			(group_addr[g % 4][LSB +: upac_pkg::ADDR_W] == i_in_phy_addr); // R06 R08 R11
	end

	// hit priority: groups before links, lowest number first; disabled ports never answer
	always_comb
	begin
		next_hit = 1'b0;
		next_hit_group = 1'b0;
		next_hit_index = 4'h0;
		if (i_in_addr_valid)
		begin
			for (int k = upac_pkg::NUM_LINKS - 1; k >= 0; k--)
				if (link_match[k])
				begin
					next_hit = 1'b1; // R11
					next_hit_group = 1'b0;
					next_hit_index = 4'(k);
				end
			for (int g = upac_pkg::NUM_GROUPS - 1; g >= 0; g--)
				if (group_match[g])
				begin
					next_hit = 1'b1; // R11
					next_hit_group = 1'b1;
					next_hit_index = 4'(g);
				end
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			hit <= 1'b0;
			hit_group <= 1'b0;
			hit_index <= 4'h0;
		end
		else
		begin
			hit <= next_hit;
			hit_group <= next_hit_group;
			hit_index <= next_hit_index;
		end
	end

	// match result stands for one cycle per polled address
	assign o_in_addr_hit = hit;
	assign o_in_hit_group = hit_group;
	assign o_in_hit_index = hit_index;
endmodule

// >>> verif/upac_assertions.sv
// port assertions for the cell-bus configuration bank
module upac_assertions (
	input wire logic i_clk_sys, // clock
	input wire logic i_srst, // reset
	input wire logic [11:0] i_paddr, // apb address
	input wire logic i_psel, // apb select
	input wire logic i_penable, // apb enable
	input wire logic i_pwrite, // apb direction
	input wire logic [31:0] i_pwdata, // apb data
	input wire logic [31:0] o_prdata, // read data
	input wire logic o_pslverr, // apb error
	input wire upac_pkg::upac_cell_word_s i_cell_word, // cell word in
	input wire logic i_cell_valid, // cell strobe
	input wire upac_pkg::upac_out_word_s o_cell_out, // cell word out
	input wire logic o_bus_8bit, // bus width
	input wire logic i_in_addr_valid, // poll strobe
	input wire logic o_in_addr_hit, // hit
	input wire logic o_in_hit_group, // group hit
	input wire logic [3:0] o_in_hit_index // hit number
);
	logic [9:0] sh; // shadow of user byte and parity bits
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_srst);
	// shadow assumes full-word writes, which is all the bench issues
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			sh <= 10'h000;
		else if (i_psel && i_penable && i_pwrite && i_paddr == 12'h048 && !o_pslverr)
			sh <= i_pwdata[9:0];
	end
	chk_rdata_upper: assert property (o_prdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	chk_cell_latency: assert property (i_cell_valid |=> o_cell_out.valid)
		else $error("cell word not passed on");
	chk_udb_insert: assert property (i_cell_valid && i_cell_word.idx == 5'h02 && !o_bus_8bit
		|=> o_cell_out.data[7:0] == $past(sh[7:0])) else $error("user byte not inserted");
	chk_parity_sel: assert property (o_cell_out.valid |-> o_cell_out.parity ==
		($past(sh[8]) ? ^o_cell_out.data : ~^o_cell_out.data)) else $error("parity sense wrong");
	chk_parity_oe: assert property (!$past(i_srst) |-> o_cell_out.parity_oe == !$past(sh[9]))
		else $error("parity enable wrong");
	chk_narrow_bus: assert property (o_bus_8bit && o_cell_out.valid
		|-> o_cell_out.data[15:8] == 8'h00) else $error("upper byte driven in narrow mode");
	chk_hit_cause: assert property (o_in_addr_hit |-> $past(i_in_addr_valid))
		else $error("hit without polled address");
	chk_group_index: assert property (o_in_hit_group |-> o_in_addr_hit && o_in_hit_index < 4'h8)
		else $error("group hit out of range");
endmodule

// >>> verif/upac_atm_master.sv
// far-side model: cell-layer master offering words and polling addresses
module upac_atm_master (
	input wire logic i_clk_sys, // clock
	output upac_pkg::upac_cell_word_s o_cell_word, // word to the bank
	output logic o_cell_valid, // word strobe
	output logic [4:0] o_phy_addr, // polled address
	output logic o_addr_valid // poll strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		o_cell_word = '0;
		o_cell_valid = 1'b0;
		o_phy_addr = 5'h00;
		o_addr_valid = 1'b0;
	end
	// idle lines show the inverse of the last value, so stale data never looks valid
	task automatic send(input logic [4:0] idx, input logic [15:0] d);
		@(posedge i_clk_sys);
		o_cell_word <= '{data: d, idx: idx};
		o_cell_valid <= 1'b1;
		@(posedge i_clk_sys);
		o_cell_valid <= 1'b0;
		o_cell_word <= ~{d, idx};
	endtask
	task automatic poll(input logic [4:0] a);
		@(posedge i_clk_sys);
		o_phy_addr <= a;
		o_addr_valid <= 1'b1;
		@(posedge i_clk_sys);
		o_addr_valid <= 1'b0;
		o_phy_addr <= ~a;
	endtask
endmodule

// >>> verif/tb_upac_top.sv
// self-checking bench for the cell-bus configuration bank
module tb_upac_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic perr;
	upac_pkg::upac_cell_word_s cw;
	upac_pkg::upac_out_word_s co;
	logic cv, av, bus8, hit, hgrp;
	logic [4:0] pa;
	logic [3:0] hidx;
	logic [31:0] rd;
	logic er;
	int n_mismatch = 0;
	int cmp_count = 0;
	always #25 clk = ~clk;
	upac_top u_upac_top (.i_clk_sys(clk), .i_srst(srst), .i_paddr(paddr), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_pwdata(pwdata), .i_pstrb(4'hf), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(perr), .i_cell_word(cw), .i_cell_valid(cv),
		.o_cell_out(co), .o_bus_8bit(bus8), .i_in_phy_addr(pa), .i_in_addr_valid(av),
		.o_in_addr_hit(hit), .o_in_hit_group(hgrp), .o_in_hit_index(hidx));
	upac_atm_master u_upac_atm_master (.i_clk_sys(clk), .o_cell_word(cw), .o_cell_valid(cv),
		.o_phy_addr(pa), .o_addr_valid(av));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// one apb transfer; read data and error are taken at the ready edge only
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1)
		begin
			n_mismatch++;
			results();
		end
		rd = prdata;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	// register index in the top byte, bits the bench expects to read back below
	function automatic logic [23:0] reg_at(input int i);
		logic [7:0] b;
		b = i[7:0];
		if (i < 2)
			return {8'h12 + b, i == 0 ? 16'h03ff : 16'h0001};
		if (i < 14)
			return {8'h3e + b, 16'h1f1f};
		return {8'h42 + b, i == 14 ? 16'hffff : 16'h00ff};
	endfunction
	initial
	begin
		logic [23:0] r;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		// reset values, then all ones read back through the unused-bit masks
		for (int i = 0; i < 16; i++)
		begin
			r = reg_at(i);
			apb(1'b0, r[23:16], 32'h00000000);
			check("reset value", rd, 32'h00000000);
			// reserved bits are written as zero, unused bits as one
			apb(1'b1, r[23:16], i == 0 ? 32'hfffff3ff : i == 15 ? 32'hfffff0ff : 32'hffffffff);
			apb(1'b0, r[23:16], 32'h00000000);
			check("readback", rd, {16'h0000, r[15:0]});
		end
		apb(1'b1, 8'h54, 32'hffffffff);
		check("unmapped error", er, 1'b1);
		check("unmapped data", rd, 32'h00000000);
		$display("test registers done");
		// link k answers on address k, group g on 16+g
		for (int i = 0; i < 8; i++)
			apb(1'b1, 8'h40 + i[7:0], {19'h0, 5'(i + 8), 3'h0, 5'(i)});
		for (int i = 0; i < 4; i++)
			apb(1'b1, 8'h48 + i[7:0], {19'h0, 5'(i + 20), 3'h0, 5'(i + 16)});
		for (int e = 0; e < 2; e++)
		begin
			apb(1'b1, 8'h50, e ? 32'h0000ffff : 32'h00000000);
			apb(1'b1, 8'h51, e ? 32'h000000ff : 32'h00000000);
			for (int a = 0; a < 24; a++)
			begin
				u_upac_atm_master.poll(5'(a));
				#1;
				check("hit", {hit, hgrp, hidx}, e ? {1'b1, a >= 16, 4'(a % 16)} : 6'h00);
			end
		end
		$display("test address match done");
		apb(1'b1, 8'h13, 32'h00000000);
		for (int p = 0; p < 4; p++)
		begin
			apb(1'b1, 8'h12, {22'h0, 2'(p), 8'ha5});
			u_upac_atm_master.send(5'h02, 16'h1234);
			#1;
			check("user byte word", co.data, 16'h12a5);
			check("parity", co.parity, p[0] ? ^16'h12a5 : ~^16'h12a5);
			check("parity enable", co.parity_oe, !p[1]);
			u_upac_atm_master.send(5'h01, 16'h1234);
			#1;
			check("plain word", co.data, 16'h1234);
		end
		apb(1'b1, 8'h13, 32'h00000001);
		u_upac_atm_master.send(5'h02, 16'h1234);
		#1;
		check("bus width", bus8, 1'b1);
		check("narrow word", co.data, 16'h0034);
		$display("test cell path done");
		results();
	end
endmodule
bind upac_top upac_assertions u_upac_assertions (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
	.i_paddr(i_paddr), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
	.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_cell_word(i_cell_word),
	.i_cell_valid(i_cell_valid), .o_cell_out(o_cell_out), .o_bus_8bit(o_bus_8bit),
	.i_in_addr_valid(i_in_addr_valid), .o_in_addr_hit(o_in_addr_hit),
	.o_in_hit_group(o_in_hit_group), .o_in_hit_index(o_in_hit_index));
